// ==== design/io_space_pkg.sv ====
package io_space_pkg;

    // Operations the core presents on the request port
    typedef enum logic [2:0] {
        OP_IO_IN = 3'b000,
        OP_IO_OUT = 3'b001,
        OP_IO_BIT_SET = 3'b010,
        OP_IO_BIT_CLEAR = 3'b011,
        OP_SKIP_IF_SET = 3'b100,
        OP_SKIP_IF_CLEAR = 3'b101,
        OP_DATA_LOAD = 3'b110,
        OP_DATA_STORE = 3'b111
    } io_op_t;

    localparam logic [7:0] IO_ADDR_LAST = 8'h3F;
    localparam logic [7:0] IO_BIT_ADDR_LAST = 8'h1F;
    localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
    localparam logic [7:0] EXT_IO_FIRST = 8'h60;
    localparam logic [7:0] WINDOW_FIRST = 8'h44;
    localparam logic [7:0] WINDOW_LAST = 8'h69;
    localparam logic [7:0] REG_RESET = 8'h00;

    localparam logic [7:0] ADDR_TIMER0_CONTROL_A = 8'h44;
    localparam logic [7:0] ADDR_TIMER0_CONTROL_B = 8'h45;
    localparam logic [7:0] ADDR_TIMER0_COUNT = 8'h46;
    localparam logic [7:0] ADDR_TIMER0_COMPARE_A = 8'h47;
    localparam logic [7:0] ADDR_TIMER0_COMPARE_B = 8'h48;
    localparam logic [7:0] ADDR_GENERAL_SCRATCH_1 = 8'h4A;
    localparam logic [7:0] ADDR_GENERAL_SCRATCH_2 = 8'h4B;
    localparam logic [7:0] ADDR_SERIAL_PERIPH_CONTROL = 8'h4C;
    localparam logic [7:0] ADDR_SERIAL_PERIPH_STATUS = 8'h4D;
    localparam logic [7:0] ADDR_SERIAL_PERIPH_DATA = 8'h4E;
    localparam logic [7:0] ADDR_COMPARATOR_CONTROL_STATUS = 8'h50;
    localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h53;
    localparam logic [7:0] ADDR_RESET_CAUSE_STATUS = 8'h54;
    localparam logic [7:0] ADDR_CORE_CONTROL = 8'h55;
    localparam logic [7:0] ADDR_SELF_PROGRAM_CONTROL = 8'h57;
    localparam logic [7:0] ADDR_STACK_POINTER_LOW = 8'h5D;
    localparam logic [7:0] ADDR_STACK_POINTER_HIGH = 8'h5E;
    localparam logic [7:0] ADDR_PROCESSOR_STATUS_FLAGS = 8'h5F;
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL_STATUS = 8'h60;
    localparam logic [7:0] ADDR_CLOCK_DIVIDER_CONTROL = 8'h61;
    localparam logic [7:0] ADDR_POWER_REDUCTION_CONTROL = 8'h64;
    localparam logic [7:0] ADDR_OSCILLATOR_TRIM = 8'h66;
    localparam logic [7:0] ADDR_PIN_CHANGE_IRQ_ENABLE = 8'h68;
    localparam logic [7:0] ADDR_EXTERNAL_IRQ_SENSE_CONTROL = 8'h69;

    // Bits held in the store; reserved, flag and live bits are excluded
    localparam logic [7:0] WM_TIMER0_CONTROL_A = 8'hF3;
    localparam logic [7:0] WM_TIMER0_CONTROL_B = 8'h0F;
    localparam logic [7:0] WM_FULL = 8'hFF;
    localparam logic [7:0] WM_SERIAL_PERIPH_STATUS = 8'h01;
    localparam logic [7:0] WM_COMPARATOR_CONTROL_STATUS = 8'hCF;
    localparam logic [7:0] WM_SLEEP_CONTROL = 8'h0F;
    localparam logic [7:0] WM_CORE_CONTROL = 8'h73;
    localparam logic [7:0] WM_SELF_PROGRAM_CONTROL = 8'h9F;
    localparam logic [7:0] WM_STACK_POINTER_HIGH = 8'h07;
    localparam logic [7:0] WM_WATCHDOG_CONTROL_STATUS = 8'h7F;
    localparam logic [7:0] WM_CLOCK_DIVIDER_CONTROL = 8'h8F;
    localparam logic [7:0] WM_POWER_REDUCTION_CONTROL = 8'hEF;
    localparam logic [7:0] WM_PIN_CHANGE_IRQ_ENABLE = 8'h07;
    localparam logic [7:0] WM_EXTERNAL_IRQ_SENSE_CONTROL = 8'h0F;
    localparam logic [7:0] WM_NONE = 8'h00;

    // Flag, live and force strobe bit positions
    localparam int SPI_DONE_BIT = 7;
    localparam int SPI_COLLISION_BIT = 6;
    localparam int COMP_OUT_BIT = 5;
    localparam int COMP_EVENT_BIT = 4;
    localparam int RWW_BUSY_BIT = 6;
    localparam int WDT_EVENT_BIT = 7;
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;

endpackage

// ==== design/io_reg_store.sv ====
`timescale 1ns/1ns
`default_nettype none

module io_reg_store
    import io_space_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_index,
    input wire logic [WIDTH-1:0] wr_bits,
    input wire logic [WIDTH-1:0] wr_val,
    input wire logic [AW-1:0] rd_index,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [WIDTH-1:0] rd_data_next;

    // Per-bit write so single-bit operations touch only their bit
    always_comb
    begin
        mem_next = mem_reg;
        if (wr_en)
        begin
            mem_next[wr_index] = (mem_reg[wr_index] & ~wr_bits)
                | (wr_val & wr_bits);
        end
        rd_data_next = mem_reg[rd_index];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= WIDTH'(REG_RESET);
            end
            rd_data <= WIDTH'(REG_RESET);
        end
        else
        begin
            mem_reg <= mem_next;
            rd_data <= rd_data_next;
        end
    end

endmodule
`default_nettype wire

// ==== design/io_space_address_decoder.sv ====
// Function
// - Bit-set and bit-clear work on I/O addresses 0x00 to 0x1F.
// - Skip tests on a single bit work in the low bit range.
// - Certain flags clear on writing one; writing zero leaves them.
// - Single-bit operations change only the addressed bit, no other flags.
// - Direct I/O operations use a 6-bit address, 0x00 to 0x3F.
// - Data-space access maps to I/O address plus 0x20.
// - Extended range 0x60 to 0xFF reachable only by data-space access.
`timescale 1ns/1ns
`default_nettype none

module io_space_address_decoder
    import io_space_pkg::*;
#(
    parameter int DEPTH = 64
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire io_op_t req_op,
    input wire logic [7:0] req_addr,
    input wire logic [2:0] req_bit,
    input wire logic [7:0] req_wdata,
    input wire logic spi_done_evt,
    input wire logic spi_collision_evt,
    input wire logic comp_evt,
    input wire logic comp_out,
    input wire logic wdt_evt,
    input wire logic rww_busy,
    input wire logic [3:0] reset_cause_evt,
    output logic resp_valid,
    output logic [7:0] resp_rdata,
    output logic resp_skip,
    output logic resp_hit,
    output logic resp_refused,
    output logic timer0_force_a,
    output logic timer0_force_b
);

    function automatic logic [7:0] write_mask(input logic [7:0] a);
        case (a)
            ADDR_TIMER0_CONTROL_A: write_mask = WM_TIMER0_CONTROL_A;
            ADDR_TIMER0_CONTROL_B: write_mask = WM_TIMER0_CONTROL_B;
            ADDR_TIMER0_COUNT: write_mask = WM_FULL;
            ADDR_TIMER0_COMPARE_A: write_mask = WM_FULL;
            ADDR_TIMER0_COMPARE_B: write_mask = WM_FULL;
            ADDR_GENERAL_SCRATCH_1: write_mask = WM_FULL;
            ADDR_GENERAL_SCRATCH_2: write_mask = WM_FULL;
            ADDR_SERIAL_PERIPH_CONTROL: write_mask = WM_FULL;
            ADDR_SERIAL_PERIPH_STATUS: write_mask = WM_SERIAL_PERIPH_STATUS;
            ADDR_SERIAL_PERIPH_DATA: write_mask = WM_FULL;
            ADDR_COMPARATOR_CONTROL_STATUS:
                write_mask = WM_COMPARATOR_CONTROL_STATUS;
            ADDR_SLEEP_CONTROL: write_mask = WM_SLEEP_CONTROL;
            ADDR_CORE_CONTROL: write_mask = WM_CORE_CONTROL;
            ADDR_SELF_PROGRAM_CONTROL: write_mask = WM_SELF_PROGRAM_CONTROL;
            ADDR_STACK_POINTER_LOW: write_mask = WM_FULL;
            ADDR_STACK_POINTER_HIGH: write_mask = WM_STACK_POINTER_HIGH;
            ADDR_PROCESSOR_STATUS_FLAGS: write_mask = WM_FULL;
            ADDR_WATCHDOG_CONTROL_STATUS:
                write_mask = WM_WATCHDOG_CONTROL_STATUS;
            ADDR_CLOCK_DIVIDER_CONTROL: write_mask = WM_CLOCK_DIVIDER_CONTROL;
            ADDR_POWER_REDUCTION_CONTROL:
                write_mask = WM_POWER_REDUCTION_CONTROL;
            ADDR_OSCILLATOR_TRIM: write_mask = WM_FULL;
            ADDR_PIN_CHANGE_IRQ_ENABLE: write_mask = WM_PIN_CHANGE_IRQ_ENABLE;
            ADDR_EXTERNAL_IRQ_SENSE_CONTROL:
                write_mask = WM_EXTERNAL_IRQ_SENSE_CONTROL;
            default: write_mask = WM_NONE;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ADDR_RESET_CAUSE_STATUS) || (write_mask(a) != WM_NONE);
    endfunction

    // Request decode
    logic is_io_op;
    logic is_bit_op;
    logic is_skip_op;
    logic is_write;
    logic addr_ok;
    logic [7:0] data_addr;
    logic hit;
    logic [7:0] bit_onehot;
    logic [7:0] wr_bits;
    logic [7:0] wr_val;
    logic do_write;
    logic [7:0] store_bits;
    logic [7:0] live_bits;
    logic [7:0] live_mask;

    always_comb
    begin
        is_io_op = (req_op != OP_DATA_LOAD) && (req_op != OP_DATA_STORE);
        is_bit_op = (req_op == OP_IO_BIT_SET) || (req_op == OP_IO_BIT_CLEAR);
        is_skip_op = (req_op == OP_SKIP_IF_SET)
            || (req_op == OP_SKIP_IF_CLEAR);
        is_write = is_bit_op || (req_op == OP_IO_OUT)
            || (req_op == OP_DATA_STORE);
        // Direct I/O is refused above address 0x3F, so it never reaches 0x60
        if (is_io_op)
        begin
            addr_ok = (req_addr <= IO_ADDR_LAST);
            if (is_bit_op || is_skip_op)
            begin
                addr_ok = (req_addr <= IO_BIT_ADDR_LAST);
            end
            data_addr = 8'(req_addr + IO_DATA_OFFSET);
        end
        else
        begin
            addr_ok = 1'b1;
            data_addr = req_addr;
        end
        hit = addr_ok && is_mapped(data_addr);
        bit_onehot = 8'h01 << req_bit;
        if (is_bit_op)
        begin
            wr_bits = bit_onehot;
            wr_val = (req_op == OP_IO_BIT_SET) ? 8'hFF : 8'h00;
        end
        else
        begin
            wr_bits = 8'hFF;
            wr_val = req_wdata;
        end
        do_write = req_valid && is_write && hit;
        store_bits = wr_bits & write_mask(data_addr);
    end

    // Hardware-set flags; an event in the clearing cycle wins
    logic spi_done_reg;
    logic spi_done_next;
    logic spi_collision_reg;
    logic spi_collision_next;
    logic comp_event_reg;
    logic comp_event_next;
    logic wdt_event_reg;
    logic wdt_event_next;
    logic [3:0] reset_cause_reg;
    logic [3:0] reset_cause_next;
    logic [7:0] w1c;
    logic force_a_next;
    logic force_b_next;

    always_comb
    begin
        w1c = do_write ? (wr_bits & wr_val) : 8'h00;
        spi_done_next = spi_done_reg;
        spi_collision_next = spi_collision_reg;
        comp_event_next = comp_event_reg;
        wdt_event_next = wdt_event_reg;
        reset_cause_next = reset_cause_reg;
        force_a_next = 1'b0;
        force_b_next = 1'b0;
        if (data_addr == ADDR_SERIAL_PERIPH_STATUS && w1c[SPI_DONE_BIT])
        begin
            spi_done_next = 1'b0;
            spi_collision_next = 1'b0;
        end
        if (data_addr == ADDR_COMPARATOR_CONTROL_STATUS
            && w1c[COMP_EVENT_BIT])
        begin
            comp_event_next = 1'b0;
        end
        if (data_addr == ADDR_WATCHDOG_CONTROL_STATUS && w1c[WDT_EVENT_BIT])
        begin
            wdt_event_next = 1'b0;
        end
        // Reset causes clear where a zero is written into a selected bit
        if (do_write && data_addr == ADDR_RESET_CAUSE_STATUS)
        begin
            reset_cause_next = reset_cause_reg
                & ~(wr_bits[3:0] & ~wr_val[3:0]);
        end
        if (do_write && data_addr == ADDR_TIMER0_CONTROL_B)
        begin
            force_a_next = wr_bits[FORCE_A_BIT] & wr_val[FORCE_A_BIT];
            force_b_next = wr_bits[FORCE_B_BIT] & wr_val[FORCE_B_BIT];
        end
        spi_done_next = spi_done_next | spi_done_evt;
        spi_collision_next = spi_collision_next | spi_collision_evt;
        comp_event_next = comp_event_next | comp_evt;
        wdt_event_next = wdt_event_next | wdt_evt;
        reset_cause_next = reset_cause_next | reset_cause_evt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spi_done_reg <= 1'b0;
            spi_collision_reg <= 1'b0;
            comp_event_reg <= 1'b0;
            wdt_event_reg <= 1'b0;
            reset_cause_reg <= 4'h0;
            timer0_force_a <= 1'b0;
            timer0_force_b <= 1'b0;
        end
        else
        begin
            spi_done_reg <= spi_done_next;
            spi_collision_reg <= spi_collision_next;
            comp_event_reg <= comp_event_next;
            wdt_event_reg <= wdt_event_next;
            reset_cause_reg <= reset_cause_next;
            timer0_force_a <= force_a_next;
            timer0_force_b <= force_b_next;
        end
    end

    // Flag and live bits seen by the read in the request cycle
    always_comb
    begin
        live_bits = 8'h00;
        live_mask = 8'h00;
        case (data_addr)
            ADDR_SERIAL_PERIPH_STATUS:
            begin
                live_bits[SPI_DONE_BIT] = spi_done_reg;
                live_bits[SPI_COLLISION_BIT] = spi_collision_reg;
                live_mask = 8'hC0;
            end
            ADDR_COMPARATOR_CONTROL_STATUS:
            begin
                live_bits[COMP_OUT_BIT] = comp_out;
                live_bits[COMP_EVENT_BIT] = comp_event_reg;
                live_mask = 8'h30;
            end
            ADDR_RESET_CAUSE_STATUS:
            begin
                live_bits[3:0] = reset_cause_reg;
                live_mask = 8'h0F;
            end
            ADDR_SELF_PROGRAM_CONTROL:
            begin
                live_bits[RWW_BUSY_BIT] = rww_busy;
                live_mask = 8'h40;
            end
            ADDR_WATCHDOG_CONTROL_STATUS:
            begin
                live_bits[WDT_EVENT_BIT] = wdt_event_reg;
                live_mask = 8'h80;
            end
            default:
            begin
                live_bits = 8'h00;
                live_mask = 8'h00;
            end
        endcase
    end

    logic [7:0] store_rdata;

    io_reg_store #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(6)
    ) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(do_write),
        .wr_index(data_addr[5:0]),
        .wr_bits(store_bits),
        .wr_val(wr_val),
        .rd_index(data_addr[5:0]),
        .rd_data(store_rdata)
    );

    // Two-stage answer: stage one waits for the store read
    logic s1_valid_reg;
    logic s1_valid_next;
    logic s1_hit_reg;
    logic s1_hit_next;
    logic s1_refused_reg;
    logic s1_refused_next;
    logic s1_skip_op_reg;
    logic s1_skip_op_next;
    logic s1_skip_on_set_reg;
    logic s1_skip_on_set_next;
    logic [2:0] s1_bit_reg;
    logic [2:0] s1_bit_next;
    logic [7:0] s1_live_reg;
    logic [7:0] s1_live_next;
    logic [7:0] s1_rmask_reg;
    logic [7:0] s1_rmask_next;
    logic [7:0] rdata_next;
    logic skip_next;

    always_comb
    begin
        s1_valid_next = req_valid;
        s1_hit_next = req_valid && hit;
        s1_refused_next = req_valid && !addr_ok;
        s1_skip_op_next = is_skip_op;
        s1_skip_on_set_next = (req_op == OP_SKIP_IF_SET);
        s1_bit_next = req_bit;
        s1_live_next = live_bits;
        s1_rmask_next = hit ? (write_mask(data_addr) & ~live_mask) : 8'h00;
        // Unmapped or refused locations read as zero
        rdata_next = s1_hit_reg
            ? ((store_rdata & s1_rmask_reg) | s1_live_reg) : 8'h00;
        skip_next = s1_valid_reg && s1_skip_op_reg && !s1_refused_reg
            && (rdata_next[s1_bit_reg] == s1_skip_on_set_reg);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_valid_reg <= 1'b0;
            s1_hit_reg <= 1'b0;
            s1_refused_reg <= 1'b0;
            s1_skip_op_reg <= 1'b0;
            s1_skip_on_set_reg <= 1'b0;
            s1_bit_reg <= 3'h0;
            s1_live_reg <= 8'h00;
            s1_rmask_reg <= 8'h00;
            resp_valid <= 1'b0;
            resp_rdata <= 8'h00;
            resp_skip <= 1'b0;
            resp_hit <= 1'b0;
            resp_refused <= 1'b0;
        end
        else
        begin
            s1_valid_reg <= s1_valid_next;
            s1_hit_reg <= s1_hit_next;
            s1_refused_reg <= s1_refused_next;
            s1_skip_op_reg <= s1_skip_op_next;
            s1_skip_on_set_reg <= s1_skip_on_set_next;
            s1_bit_reg <= s1_bit_next;
            s1_live_reg <= s1_live_next;
            s1_rmask_reg <= s1_rmask_next;
            resp_valid <= s1_valid_reg;
            resp_rdata <= rdata_next;
            resp_skip <= skip_next;
            resp_hit <= s1_hit_reg;
            resp_refused <= s1_refused_reg;
        end
    end

endmodule
`default_nettype wire

// ==== bench/io_space_checker_sva.sv ====
`timescale 1ns/1ns
`default_nettype none

module io_space_checker
    import io_space_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire io_op_t req_op,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic resp_valid,
    input wire logic [7:0] resp_rdata,
    input wire logic resp_skip,
    input wire logic resp_hit,
    input wire logic resp_refused,
    input wire logic timer0_force_a
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic take_bit;
    logic take_io;
    assign take_bit = req_valid && req_op inside {OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR, OP_SKIP_IF_SET, OP_SKIP_IF_CLEAR};
    assign take_io = req_valid && req_op <= OP_SKIP_IF_CLEAR;

    resp_latency_a: assert property (req_valid |-> ##2 resp_valid)
        else $error("answer not two cycles after request");
    resp_cause_a: assert property (resp_valid |-> $past(req_valid, 2))
        else $error("answer without request");
    io_range_a: assert property (take_io && req_addr > 8'h3F
        |-> ##2 resp_refused && !resp_hit)
        else $error("direct access above 0x3F not refused");
    bit_range_a: assert property (take_bit && req_addr > 8'h1F
        |-> ##2 resp_refused && !resp_skip && resp_rdata == 8'h00)
        else $error("bit operation above 0x1F not refused");
    bit_accept_a: assert property (take_bit && req_addr <= 8'h1F
        |-> ##2 !resp_refused && !resp_hit)
        else $error("bit operation in low range refused");
    ext_data_a: assert property (req_valid && req_op >= OP_DATA_LOAD
        |-> ##2 !resp_refused)
        else $error("data access refused");
    io_offset_a: assert property (take_io && req_addr == 8'h3F
        && req_op <= OP_IO_OUT |-> ##2 resp_hit)
        else $error("I/O 0x3F not mapped to data 0x5F");
    reserved_zero_a: assert property (req_valid && req_addr inside
        {8'h49, 8'h4F, 8'h67} && req_op == OP_DATA_LOAD
        |-> ##2 resp_rdata == 8'h00 && !resp_hit)
        else $error("reserved location not zero");
    refuse_hit_a: assert property (resp_refused |-> !resp_hit)
        else $error("refused answer marked hit");
    force_cause_a: assert property (timer0_force_a
        |-> $past(req_valid) && ($past(req_wdata) & 8'h80) != 8'h00)
        else $error("force pulse without write of one");

    cover property (req_valid && req_op == OP_DATA_STORE ##2 resp_hit);
    cover property (take_bit ##2 resp_refused);
    cover property (timer0_force_a);
    cover property (take_bit ##2 resp_skip);
endmodule

bind io_space_address_decoder io_space_checker CHK (.clk(clk),
    .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_skip(resp_skip), .resp_hit(resp_hit),
    .resp_refused(resp_refused), .timer0_force_a(timer0_force_a));

`default_nettype wire

// ==== bench/core_issue_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module core_issue_model
    import io_space_pkg::*;
(
    input wire logic clk,
    output logic req_valid,
    output io_op_t req_op,
    output logic [7:0] req_addr,
    output logic [2:0] req_bit,
    output logic [7:0] req_wdata,
    input wire logic resp_valid,
    input wire logic [7:0] resp_rdata,
    input wire logic resp_skip,
    input wire logic resp_hit,
    input wire logic resp_refused
);
    initial
    begin
        req_valid = 1'b0;
        req_op = OP_IO_IN;
        req_addr = 8'h00;
        req_bit = 3'h0;
        req_wdata = 8'h00;
    end

    // One request, answer collected within four edges
    task automatic access(input io_op_t op, input logic [7:0] addr,
        input logic [2:0] bnum, input logic [7:0] wdata,
        output logic [7:0] rdata, output logic [2:0] st, output logic got);
        int i;
        got = 1'b0;
        rdata = 8'h00;
        st = 3'h0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= addr;
        req_bit <= bnum;
        req_wdata <= wdata;
        @(posedge clk);
        // Released address, bit and data lines show the inverse; req_op keeps the last value
        req_valid <= 1'b0;
        req_addr <= ~addr;
        req_bit <= ~bnum;
        req_wdata <= ~wdata;
        for (i = 0; i < 4 && !got; i++)
        begin
            @(posedge clk);
            #1;
            if (resp_valid === 1'b1)
            begin
                got = 1'b1;
                rdata = resp_rdata;
                st = {resp_skip, resp_hit, resp_refused};
            end
        end
    endtask
endmodule

`default_nettype wire

// ==== bench/io_space_address_decoder_test.sv ====
`timescale 1ns/1ns
`default_nettype none

module io_space_address_decoder_test;
    import io_space_pkg::*;

    logic clk, rst_n, req_valid, resp_valid, resp_skip, resp_hit;
    logic resp_refused, force_a, force_b, got;
    logic spi_done_evt, spi_collision_evt, comp_evt, comp_out;
    logic wdt_evt, rww_busy;
    logic [3:0] reset_cause_evt;
    io_op_t req_op;
    logic [7:0] req_addr, req_wdata, resp_rdata, rd;
    logic [2:0] req_bit, st;
    int fail_count, total_checks, force_count, i;
    logic [7:0] ma [24] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h4A,
        8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h50, 8'h53, 8'h54, 8'h55, 8'h57,
        8'h5D, 8'h5E, 8'h5F, 8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h69};
    logic [7:0] mm [24] = '{8'hF3, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hCF, 8'h0F, 8'h00, 8'h73, 8'h9F,
        8'hFF, 8'h07, 8'hFF, 8'h7F, 8'h8F, 8'hEF, 8'hFF, 8'h07, 8'h0F};
    logic [7:0] ra [13] = '{8'h49, 8'h4F, 8'h51, 8'h52, 8'h56, 8'h58,
        8'h5C, 8'h62, 8'h63, 8'h65, 8'h67, 8'h6A, 8'h43};
    logic [7:0] fa [3] = '{8'h4D, 8'h50, 8'h60};
    logic [7:0] fe [3] = '{8'hC0, 8'h10, 8'h80};
    logic [7:0] fw [3] = '{8'h80, 8'h10, 8'h80};

    io_space_address_decoder DUT (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_bit(req_bit), .req_wdata(req_wdata),
        .spi_done_evt(spi_done_evt), .spi_collision_evt(spi_collision_evt),
        .comp_evt(comp_evt), .comp_out(comp_out), .wdt_evt(wdt_evt),
        .rww_busy(rww_busy), .reset_cause_evt(reset_cause_evt),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_skip(resp_skip), .resp_hit(resp_hit),
        .resp_refused(resp_refused), .timer0_force_a(force_a),
        .timer0_force_b(force_b));

    core_issue_model P (.clk(clk), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_skip(resp_skip), .resp_hit(resp_hit),
        .resp_refused(resp_refused));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (force_a === 1'b1)
            force_count++;
        if (force_b === 1'b1)
            force_count++;
    end

    task automatic check8(input string what, input logic [7:0] exp,
        input logic [7:0] act);
        total_checks++;
        if (act !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, act);
            fail_count++;
        end
    endtask

    // Status compared as {skip, hit, refused}
    task automatic xfer(input io_op_t op, input logic [7:0] addr,
        input logic [7:0] wdata, input logic [7:0] exp_rd,
        input logic [2:0] exp_st);
        P.access(op, addr, 3'h7, wdata, rd, st, got);
        check8("resp_valid", 8'h01, {7'h00, got});
        check8($sformatf("rdata op %0d addr %h", op, addr), exp_rd, rd);
        check8($sformatf("status op %0d addr %h", op, addr),
            {5'h00, exp_st}, {5'h00, st});
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: {spi_done_evt, spi_collision_evt} <= 2'b11;
            1: comp_evt <= 1'b1;
            2: wdt_evt <= 1'b1;
            default: reset_cause_evt <= 4'hF;
        endcase
        @(posedge clk);
        {spi_done_evt, spi_collision_evt, comp_evt, wdt_evt} <= 4'h0;
        reset_cause_evt <= 4'h0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        rst_n = 1'b0;
        {spi_done_evt, spi_collision_evt, comp_evt, comp_out} = 4'h0;
        {wdt_evt, rww_busy} = 2'b00;
        reset_cause_evt = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 24; i++)
        begin
            xfer(OP_DATA_LOAD, ma[i], 8'h00, 8'h00, 3'b010);
            xfer(OP_DATA_STORE, ma[i], 8'hFF, 8'h00, 3'b010);
            if (ma[i] < 8'h60)
            begin
                xfer(OP_IO_IN, ma[i] - 8'h20, 8'h00, mm[i], 3'b010);
                xfer(OP_IO_OUT, ma[i] - 8'h20, 8'h00, mm[i], 3'b010);
            end
            else
            begin
                xfer(OP_IO_IN, ma[i] - 8'h20, 8'h00, 8'h00, 3'b001);
                xfer(OP_IO_OUT, ma[i] - 8'h20, 8'h00, 8'h00, 3'b001);
                xfer(OP_DATA_LOAD, ma[i], 8'h00, mm[i], 3'b010);
                xfer(OP_DATA_STORE, ma[i], 8'h00, mm[i], 3'b010);
            end
            xfer(OP_DATA_LOAD, ma[i], 8'h00, 8'h00, 3'b010);
        end
        check8("force pulses", 8'h02, force_count[7:0]);
        $display("test register map done");
        for (i = 0; i < 13; i++)
        begin
            xfer(OP_DATA_STORE, ra[i], 8'hFF, 8'h00, 3'b000);
            xfer(OP_DATA_LOAD, ra[i], 8'h00, 8'h00, 3'b000);
        end
        $display("test reserved done");
        xfer(OP_DATA_STORE, 8'h44, 8'h33, 8'h00, 3'b010);
        for (i = 2; i < 6; i++)
            xfer(io_op_t'(i), 8'h24, 8'h00, 8'h00, 3'b001);
        xfer(OP_DATA_LOAD, 8'h44, 8'h00, 8'h33, 3'b010);
        xfer(OP_IO_IN, 8'h40, 8'h00, 8'h00, 3'b001);
        xfer(OP_IO_OUT, 8'h40, 8'hFF, 8'h00, 3'b001);
        xfer(OP_IO_BIT_SET, 8'h1F, 8'h00, 8'h00, 3'b000);
        xfer(OP_SKIP_IF_CLEAR, 8'h10, 8'h00, 8'h00, 3'b100);
        xfer(OP_SKIP_IF_SET, 8'h10, 8'h00, 8'h00, 3'b000);
        $display("test refusal done");
        for (i = 0; i < 3; i++)
        begin
            pulse(i);
            xfer(OP_DATA_LOAD, fa[i], 8'h00, fe[i], 3'b010);
            xfer(OP_DATA_STORE, fa[i], 8'h00, fe[i], 3'b010);
            xfer(OP_DATA_STORE, fa[i], fw[i], fe[i], 3'b010);
            xfer(OP_DATA_LOAD, fa[i], 8'h00, 8'h00, 3'b010);
        end
        pulse(3);
        xfer(OP_DATA_STORE, 8'h54, 8'h0A, 8'h0F, 3'b010);
        xfer(OP_DATA_LOAD, 8'h54, 8'h00, 8'h0A, 3'b010);
        @(posedge clk);
        {comp_out, rww_busy} <= 2'b11;
        xfer(OP_IO_IN, 8'h30, 8'h00, 8'h20, 3'b010);
        xfer(OP_IO_IN, 8'h37, 8'h00, 8'h40, 3'b010);
        $display("test flags done");
        report_and_stop();
    end
endmodule

`default_nettype wire
